// ===== rtl/fsa_align.sv
// Purpose: Frame/sync pulse alignment of one loop's output dividers
// Assumes: Pulse and reference inputs are pins sampled by CLK_SYS
// Notes: Output clock and pulse come from free-running dividers
//
// Behaviour
// - Frame mode: active pulse edge arms; next reference rising edge aligns.
// - Active edge of the pulse input selectable as rising or falling.
// - Pulse rates PULSE_PER_EVEN_SECOND to 8kHz accepted, each with a selectable reference.
// - Output clock and output pulse dividers must form an integer ratio.
// - Outputs align to first reference rising edge after the frame pulse.
// - With alignment enabled in frame mode, outputs realign to the paired reference.
// - Rising pulse edge by default; falling edge when edge bit set.
// - Sync mode: the pulse edge itself is the alignment edge.
// - Sync mode aligns to first rising, or falling, sync pulse edge.
// - Any input may be pulse or reference; chosen by select bits.
// - System oscillator input has no monitor and raises no alarm.
`timescale 1ns/1ps
module fsa_align (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // Pins
    input wire logic [fsa_pkg::FSA_NUM_IN-1:0] PULSE_IN,
    // Control
    input wire logic ALIGN_ENABLE,
    input wire logic SYNC_MODE,
    input wire logic FALL_EDGE,
    input wire logic [fsa_pkg::FSA_SEL_W-1:0] PULSE_SEL,
    input wire logic [fsa_pkg::FSA_SEL_W-1:0] REF_SEL,
    input wire logic [fsa_pkg::FSA_RATE_W-1:0] PULSE_RATE,
    input wire logic [fsa_pkg::FSA_DIV_W-1:0] CLK_HALF_DIV,
    input wire logic [fsa_pkg::FSA_DIV_W-1:0] PULSE_RATIO,
    input wire logic [fsa_pkg::FSA_WID_W-1:0] PULSE_WIDTH,
    // Outputs and status
    output logic ALIGNED_CLOCK_OUTPUT,
    output logic ALIGNED_PULSE_OUTPUT,
    output logic ALIGN_EVENT,
    output logic ARMED,
    output logic RATE_ERR
);
    import fsa_pkg::*;

    logic [FSA_NUM_IN-1:0] in_rise;
    logic [FSA_NUM_IN-1:0] in_fall;
    logic pulse_edge;
    logic ref_rise;
    logic rate_ok;
    fsa_state_t state;
    fsa_state_t next_state;
    logic next_align_event;
    logic next_rate_err;
    logic [FSA_DIV_W-1:0] half_div;
    logic [FSA_DIV_W-1:0] ratio;
    logic [FSA_WID_W-1:0] width;
    logic [FSA_DIV_W-1:0] clk_cnt;
    logic [FSA_DIV_W-1:0] next_clk_cnt;
    logic [FSA_DIV_W-1:0] frm_cnt;
    logic [FSA_DIV_W-1:0] next_frm_cnt;
    logic [FSA_WID_W-1:0] wid_cnt;
    logic [FSA_WID_W-1:0] next_wid_cnt;
    logic clk_out;
    logic next_clk_out;
    logic pulse_out;
    logic next_pulse_out;

    // Any pin may serve as pulse input or reference
    genvar gi;
    generate
        for (gi = 0; gi < FSA_NUM_IN; gi++) begin : g_in
            fsa_edge_sync u_sync (
                .clk(CLK_SYS),
                .rst(RST),
                .raw(PULSE_IN[gi]),
                .rise(in_rise[gi]),
                .fall(in_fall[gi])
            );
        end
    endgenerate

    assign pulse_edge = FALL_EDGE ? in_fall[PULSE_SEL] : in_rise[PULSE_SEL];
    assign ref_rise = in_rise[REF_SEL];
    assign rate_ok = (PULSE_RATE <= FSA_RATE_8KHZ);

    // Zero settings behave as one
    assign half_div = (CLK_HALF_DIV == FSA_DIV_ZERO) ? FSA_DIV_ONE
                                                     : CLK_HALF_DIV;
    assign ratio = (PULSE_RATIO == FSA_DIV_ZERO) ? FSA_DIV_ONE : PULSE_RATIO;
    assign width = (PULSE_WIDTH == FSA_WID_ZERO) ? FSA_WID_ONE : PULSE_WIDTH;

    // Alignment sequencer; the oscillator input has no alarm here
    always_comb begin
        next_state = state;
        case (state)
            FSA_FREE: begin
                if (ALIGN_ENABLE && rate_ok && pulse_edge) begin
                    if (SYNC_MODE) begin
                        next_state = FSA_ALIGN;
                    end else begin
                        next_state = FSA_ARMED;
                    end
                end
            end
            FSA_ARMED: begin
                if (!ALIGN_ENABLE || !rate_ok) begin
                    next_state = FSA_FREE;
                end else if (ref_rise) begin
                    next_state = FSA_ALIGN;
                end
            end
            FSA_ALIGN: begin
                next_state = FSA_FREE;
            end
            default: begin
                next_state = FSA_FREE;
            end
        endcase
        next_align_event = (next_state == FSA_ALIGN);
        next_rate_err = !rate_ok;
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state <= FSA_FREE;
            ALIGN_EVENT <= 1'b0;
            ARMED <= 1'b0;
            RATE_ERR <= 1'b0;
        end else begin
            state <= next_state;
            ALIGN_EVENT <= next_align_event;
            ARMED <= (next_state == FSA_ARMED);
            RATE_ERR <= next_rate_err;
        end
    end

    // Output dividers; the pulse counts whole output clock periods
    always_comb begin
        next_clk_cnt = clk_cnt;
        next_frm_cnt = frm_cnt;
        next_wid_cnt = wid_cnt;
        next_clk_out = clk_out;
        next_pulse_out = pulse_out;
        if (state == FSA_ALIGN) begin
            // Restart both dividers on the alignment edge
            next_clk_cnt = half_div - FSA_DIV_ONE;
            next_frm_cnt = ratio - FSA_DIV_ONE;
            next_wid_cnt = width - FSA_WID_ONE;
            next_clk_out = 1'b1;
            next_pulse_out = 1'b1;
        end else begin
            // Free running when not aligning
            if (wid_cnt != FSA_WID_ZERO) begin
                next_wid_cnt = wid_cnt - FSA_WID_ONE;
            end else begin
                next_pulse_out = 1'b0;
            end
            if (clk_cnt != FSA_DIV_ZERO) begin
                next_clk_cnt = clk_cnt - FSA_DIV_ONE;
            end else begin
                next_clk_cnt = half_div - FSA_DIV_ONE;
                next_clk_out = !clk_out;
                if (!clk_out) begin
                    if (frm_cnt != FSA_DIV_ZERO) begin
                        next_frm_cnt = frm_cnt - FSA_DIV_ONE;
                    end else begin
                        next_frm_cnt = ratio - FSA_DIV_ONE;
                        next_wid_cnt = width - FSA_WID_ONE;
                        next_pulse_out = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            clk_cnt <= FSA_DIV_ZERO;
            frm_cnt <= FSA_DIV_ZERO;
            wid_cnt <= FSA_WID_ZERO;
            clk_out <= 1'b0;
            pulse_out <= 1'b0;
        end else begin
            clk_cnt <= next_clk_cnt;
            frm_cnt <= next_frm_cnt;
            wid_cnt <= next_wid_cnt;
            clk_out <= next_clk_out;
            pulse_out <= next_pulse_out;
        end
    end

    assign ALIGNED_CLOCK_OUTPUT = clk_out;
    assign ALIGNED_PULSE_OUTPUT = pulse_out;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    sequence s_frame_armed;
        state == FSA_FREE && ALIGN_ENABLE && rate_ok && pulse_edge
            && !SYNC_MODE;
    endsequence

    sequence s_ref_seen;
        state == FSA_ARMED && ALIGN_ENABLE && rate_ok && ref_rise;
    endsequence

    property p_frame_arm;
        s_frame_armed |=> state == FSA_ARMED && ARMED;
    endproperty
    a_frame_arm: assert property (p_frame_arm)
        else $error("frame edge did not arm");

    property p_frame_wait;
        state == FSA_ARMED && ALIGN_ENABLE && rate_ok && !ref_rise
            |=> state == FSA_ARMED && !ALIGN_EVENT;
    endproperty
    a_frame_wait: assert property (p_frame_wait)
        else $error("aligned without reference edge");

    property p_frame_align;
        s_ref_seen |=> ALIGN_EVENT ##1 (clk_out && pulse_out);
    endproperty
    a_frame_align: assert property (p_frame_align)
        else $error("reference edge did not realign outputs");

    property p_sync_align;
        state == FSA_FREE && ALIGN_ENABLE && rate_ok && pulse_edge
            && SYNC_MODE |=> state == FSA_ALIGN ##1 ALIGNED_PULSE_OUTPUT;
    endproperty
    a_sync_align: assert property (p_sync_align)
        else $error("sync edge did not realign");

    property p_wrong_edge;
        state == FSA_FREE && !pulse_edge |=> state == FSA_FREE;
    endproperty
    a_wrong_edge: assert property (p_wrong_edge)
        else $error("left idle without selected edge");

    property p_edge_pick;
        state == FSA_FREE && ALIGN_ENABLE && rate_ok && FALL_EDGE
            && in_fall[PULSE_SEL] |=> state != FSA_FREE;
    endproperty
    a_edge_pick: assert property (p_edge_pick)
        else $error("falling edge ignored");

    property p_disabled;
        !ALIGN_ENABLE |=> state == FSA_FREE && !ALIGN_EVENT;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("realigned while disabled");

    property p_rate;
        !rate_ok |=> state == FSA_FREE && RATE_ERR;
    endproperty
    a_rate: assert property (p_rate)
        else $error("unsupported rate not blocked");

    // A realignment may restart the pulse while the clock is already high
    property p_pulse_clock;
        $rose(pulse_out) |-> clk_out && ($rose(clk_out) || $past(ALIGN_EVENT));
    endproperty
    a_pulse_clock: assert property (p_pulse_clock)
        else $error("pulse not on output clock edge");
endmodule

// ===== rtl/fsa_pkg.sv
// Purpose: Shared constants for the frame/sync pulse alignment channel
// Assumes: One system clock; all inputs are plain pins
// Notes: Rate codes cover the supported pulse input rates
package fsa_pkg;
    localparam int FSA_NUM_IN = 16;
    localparam int FSA_SEL_W = 4;
    localparam int FSA_DIV_W = 16;
    localparam int FSA_WID_W = 8;
    localparam int FSA_RATE_W = 4;

    // Supported pulse input rates
    localparam logic [3:0] FSA_RATE_PULSE_PER_EVEN_SECOND = 4'h0;
    localparam logic [3:0] FSA_RATE_1PPS = 4'h1;
    localparam logic [3:0] FSA_RATE_5PPS = 4'h2;
    localparam logic [3:0] FSA_RATE_10PPS = 4'h3;
    localparam logic [3:0] FSA_RATE_50HZ = 4'h4;
    localparam logic [3:0] FSA_RATE_100HZ = 4'h5;
    localparam logic [3:0] FSA_RATE_1KHZ = 4'h6;
    localparam logic [3:0] FSA_RATE_2KHZ = 4'h7;
    localparam logic [3:0] FSA_RATE_4KHZ = 4'h8;
    localparam logic [3:0] FSA_RATE_8KHZ = 4'h9;

    // Reset and floor values of the dividers
    localparam logic [15:0] FSA_DIV_ONE = 16'h0001;
    localparam logic [15:0] FSA_DIV_ZERO = 16'h0000;
    localparam logic [7:0] FSA_WID_ONE = 8'h01;
    localparam logic [7:0] FSA_WID_ZERO = 8'h00;

    typedef enum logic [2:0] {
        FSA_FREE = 3'b001,
        FSA_ARMED = 3'b010,
        FSA_ALIGN = 3'b100
    } fsa_state_t;
endpackage

// ===== rtl/fsa_edge_sync.sv
// Purpose: Two-stage synchroniser with edge detection for one pin
// Assumes: Input is asynchronous to CLK_SYS
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
module fsa_edge_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pin and results
    input wire logic raw,
    output logic rise,
    output logic fall
);
    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= raw;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign rise = stage2 & ~stage3;
    assign fall = ~stage2 & stage3;
endmodule

// ===== verification/fsa_source_model.sv
// Purpose: Upstream source of pulse and reference pins
// Assumes: Pins change on the falling edge of the system clock
// Notes: Unused pins toggle every cycle to expose a wrong select
`timescale 1ns/1ps
module fsa_source_model (
    // Clock
    input wire logic clk,
    // Pin choice and reference run
    input wire logic [3:0] pulse_idx,
    input wire logic [3:0] ref_idx,
    input wire logic ref_run,
    // Pins
    output logic [15:0] pins
);
    logic pulse_lvl = 1'b0;
    logic ref_lvl = 1'b0;
    logic noise = 1'b0;
    logic [1:0] ref_cnt = 2'h0;

    // Reference of eight cycles, a whole multiple of the pulse rate
    // Only the ref_idx pin stops, held low, when ref_run drops
    always @(negedge clk) begin
        noise <= ~noise;
        if (!ref_run) begin
            ref_lvl <= 1'b0;
            ref_cnt <= 2'h0;
        end else begin
            ref_cnt <= ref_cnt + 2'h1;
            if (ref_cnt == 2'h0) begin
                ref_lvl <= ~ref_lvl;
            end
        end
    end

    always_comb begin
        pins = {16{noise}};
        pins[ref_idx] = ref_lvl;
        pins[pulse_idx] = pulse_lvl;
    end

    // Each level is held for many cycles by the caller, including the low before the final rising edge, which spans the rate checks
    task automatic drive(input logic lvl);
        @(negedge clk);
        pulse_lvl <= lvl;
    endtask
endmodule

// ===== verification/test_fsa_align.sv
// Purpose: Self-checking bench for the pulse alignment channel
// Assumes: Inputs change on the falling edge of CLK_SYS
// Notes: Latencies follow the three-flop pin path
`timescale 1ns/1ps
module test_fsa_align;
    import fsa_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic enable = 1'b0;
    logic sync = 1'b0;
    logic fall = 1'b0;
    logic ref_run = 1'b0;
    logic prev = 1'b0;
    logic [3:0] rate = FSA_RATE_1PPS;
    logic [3:0] pulse_sel = 4'h5;
    logic [3:0] ref_sel = 4'h9;
    logic [15:0] pins;
    logic clk_out, pls_out, evt, armed, rate_err;
    int mismatches = 0;
    int tests_run = 0;
    int n = 0;

    always #50 clk = ~clk;

    fsa_source_model src_u (.clk(clk), .pulse_idx(pulse_sel),
        .ref_idx(ref_sel), .ref_run(ref_run), .pins(pins));

    fsa_align dut_u (.CLK_SYS(clk), .RST(rst), .PULSE_IN(pins),
        .ALIGN_ENABLE(enable), .SYNC_MODE(sync), .FALL_EDGE(fall),
        .PULSE_SEL(pulse_sel), .REF_SEL(ref_sel), .PULSE_RATE(rate),
        .CLK_HALF_DIV(16'h0002),
        .PULSE_RATIO(16'h0004),
        .PULSE_WIDTH(8'h03), .ALIGNED_CLOCK_OUTPUT(clk_out),
        .ALIGNED_PULSE_OUTPUT(pls_out), .ALIGN_EVENT(evt), .ARMED(armed),
        .RATE_ERR(rate_err));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("%0d compares, %0d mismatches", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Falling edges until the chosen flag shows
    task automatic wait_for(input bit on_armed, output int cnt);
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
        end while ((on_armed ? armed : evt) !== 1'b1 && cnt < 12);
        if ((on_armed ? armed : evt) !== 1'b1) begin
            check(8'h00, 8'h01);
            end_of_test();
        end
    endtask

    task automatic quiet(input int cyc, input logic exp_armed);
        repeat (cyc) begin
            @(negedge clk);
            check({6'h00, armed, evt}, {6'h00, exp_armed, 1'b0});
        end
    endtask

    // First high run of both outputs after alignment
    task automatic runs();
        int c = 0;
        int p = 0;
        logic cs = 1'b1;
        logic ps = 1'b1;
        @(negedge clk);
        check({5'h00, clk_out, pls_out, evt}, 8'h06);
        repeat (10) begin
            cs = cs & clk_out;
            ps = ps & pls_out;
            c += cs;
            p += ps;
            @(negedge clk);
        end
        check(8'(c), 8'h02);
        check(8'(p), 8'h03);
    endtask

    initial begin
        repeat (10) @(negedge clk);
        check({3'h0, clk_out, pls_out, evt, armed, rate_err}, 8'h00);
        rst <= 1'b0;
        ref_run <= 1'b1;
        sync <= 1'b1;
        src_u.drive(1'b1);
        quiet(8, 1'b0);
        src_u.drive(1'b0);
        prev = clk_out;
        repeat (20) begin
            @(negedge clk);
            if (clk_out !== prev) n++;
            prev = clk_out;
        end
        check(8'(n), 8'h0a);
        $display("test free run done");
        // Edge setting and idle level change only while disabled
        for (int f = 0; f < 2; f++) begin
            enable <= 1'b0;
            fall <= f[0];
            pulse_sel <= f[0] ? 4'hc : 4'h5;
            src_u.drive(~f[0]);
            quiet(4, 1'b0);
            enable <= 1'b1;
            src_u.drive(f[0]);
            quiet(8, 1'b0);
            src_u.drive(~f[0]);
            wait_for(1'b0, n);
            check(8'(n), 8'h03);
            runs();
            $display("test sync edge %0d done", f);
        end
        sync <= 1'b0;
        for (int f = 0; f < 2; f++) begin
            enable <= 1'b0;
            fall <= f[0];
            ref_run <= 1'b0;
            src_u.drive(~f[0]);
            quiet(4, 1'b0);
            enable <= 1'b1;
            src_u.drive(f[0]);
            quiet(8, 1'b0);
            src_u.drive(~f[0]);
            wait_for(1'b1, n);
            check(8'(n), 8'h03);
            quiet(10, 1'b1);
            ref_run <= 1'b1;
            wait_for(1'b0, n);
            check({7'h00, armed}, 8'h00);
            check(8'(n), 8'h04);
            runs();
            $display("test frame edge %0d done", f);
        end
        for (int r = 0; r < 16; r++) begin
            rate <= 4'(r);
            @(negedge clk);
            @(negedge clk);
            check({7'h00, rate_err}, {7'h00, r > 9});
        end
        sync <= 1'b1;
        fall <= 1'b0;
        src_u.drive(1'b0);
        src_u.drive(1'b1);
        quiet(8, 1'b0);
        $display("test rate codes done");
        end_of_test();
    end
endmodule
